// [scrb_pkg.sv]
package scrb_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam int NREG = 16;

  // Bank codes on the BANK port
  localparam logic [2:0] BANK_A = 3'h0;
  localparam logic [2:0] BANK_B = 3'h1;
  localparam logic [2:0] BANK_F = 3'h5;
  localparam logic [2:0] BANK_G = 3'h6;
  localparam logic [2:0] BANK_H = 3'h7;

  // Register indices into the storage arrays
  localparam int IDX_UPDATE_CTRL    = 0;
  localparam int IDX_SYNTH_PWR      = 1;
  localparam int IDX_CONV_PIPE_DIV  = 2;
  localparam int IDX_LINK_CLK_DIV   = 3;
  localparam int IDX_CLK_GATE       = 4;
  localparam int IDX_SYNC_SUPPRESS  = 5;
  localparam int IDX_SYNC_SHAPE     = 6;
  localparam int IDX_FRAME_SYNC     = 7;
  localparam int IDX_TEST_PATTERN   = 8;
  localparam int IDX_LINK_ENABLE    = 9;
  localparam int IDX_CLK_PIN_STATE  = 10;
  localparam int IDX_DATA_PIN_STATE = 11;
  localparam int IDX_LANE_ROUTE     = 12;
  localparam int IDX_PIN_POL_SWAP   = 13;
  localparam int IDX_PIPE_FUNC      = 14;
  localparam int IDX_TONE_SHADING   = 15;

  // Per register: bank, offset, implemented bits, reset value (index 15 first)
  localparam logic [NREG-1:0][2:0] REG_BANK = {
    BANK_H, BANK_G, BANK_F, BANK_F, BANK_F, BANK_F, BANK_F, BANK_B,
    BANK_B, BANK_A, BANK_A, BANK_A, BANK_A, BANK_A, BANK_A, BANK_A};
  localparam logic [NREG-1:0][7:0] REG_ADDR = {
    8'h04, 8'h06, 8'h0b, 8'h09, 8'h06, 8'h05, 8'h04, 8'h11,
    8'h0a, 8'hae, 8'had, 8'h58, 8'h57, 8'h56, 8'h4e, 8'h1a};
  localparam logic [NREG-1:0][7:0] REG_MASK = {
    8'h50, 8'he1, 8'hc8, 8'h0f, 8'hff, 8'hf0, 8'h50, 8'h1e,
    8'h30, 8'h70, 8'h60, 8'hc0, 8'hd8, 8'hf0, 8'h38, 8'hf0};
  localparam logic [NREG-1:0][7:0] REG_RESET = {
    8'h00, 8'h00, 8'h00, 8'h0b, 8'haa, 8'ha0, 8'h10, 8'h00,
    8'h00, 8'h00, 8'h00, 8'hc0, 8'h50, 8'h20, 8'h38, 8'h50};
  // Registers whose fields follow the frame-synced update path
  localparam logic [NREG-1:0] REG_FRAME_SYNCED = 16'hc27c;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int UPD_FRAME_LSB  = 4;  // frame-synced update mode [5:4]
  localparam int CONV_DIV_LSB   = 6;
  localparam int PIPE_DIV_LSB   = 4;
  localparam int BIT_DIV_LSB    = 6;
  localparam int BYTE_DIV_LSB   = 3;
  localparam int PIPE_GATE_BIT  = 7;
  localparam int TONE_GATE_BIT  = 6;
  localparam int SYNTH1_PD_BIT  = 5;
  localparam int BYPASS_BIT     = 4;
  localparam int SYNTH2_PD_BIT  = 3;
  localparam int FSYNC_EN_BIT   = 5;
  localparam int FSYNC_MST_BIT  = 4;
  localparam int TP_SEL_LSB     = 3;
  localparam int TP_SEL_VS_LSB  = 1;
  localparam int SUPP_V_BIT     = 5;  // suppress code bit 0: vertical
  localparam int SUPP_H_BIT     = 6;  // suppress code bit 1: horizontal
  localparam int VINV_BIT       = 6;
  localparam int HALL_BIT       = 5;
  localparam int HINV_BIT       = 4;
  localparam int LINK_EN_BIT    = 6;
  localparam int CK_CONT_BIT    = 4;
  localparam int CK_PIN_LSB     = 4;
  localparam int D0_PIN_LSB     = 4;
  localparam int D1_PIN_LSB     = 0;
  localparam int L0_SRC_LSB     = 2;
  localparam int L1_SRC_LSB     = 0;
  localparam int L0_SWAP_BIT    = 7;
  localparam int L1_SWAP_BIT    = 6;
  localparam int CK_SWAP_BIT    = 3;
  localparam int NR_LONG_BIT    = 7;
  localparam int NR_SHORT_BIT   = 6;
  localparam int NR_VSHORT_BIT  = 5;
  localparam int DGAIN_BIT      = 0;
  localparam int LENS_BIT       = 6;
  localparam int TONE_BIT       = 4;

  // Update mode codes
  localparam logic [1:0] UPD_BLOCKED  = 2'h0;
  localparam logic [1:0] UPD_AT_FRAME = 2'h1;

  // Lane pin state codes
  typedef enum logic [3:0] {
    SCRB_PIN_NORMAL   = 4'h0,
    SCRB_PIN_LP00     = 4'h1,
    SCRB_PIN_LP01     = 4'h2,
    SCRB_PIN_LP10     = 4'h3,
    SCRB_PIN_LP11     = 4'h4,
    SCRB_PIN_HS0      = 4'h5,
    SCRB_PIN_HS1      = 4'h6,
    SCRB_PIN_HIZ      = 4'h7,
    SCRB_PIN_ULP      = 4'h8,
    SCRB_PIN_SER_TEST = 4'h9,
    SCRB_PIN_PWR_DOWN = 4'ha
  } scrb_pin_state_e;

  typedef logic [NREG-1:0][7:0] scrb_regs_t;

  typedef struct packed {
    scrb_regs_t  shadow;   // Host-visible values
    scrb_regs_t  active;   // Values driving the hardware
    logic [7:0]  rd_data;
  } scrb_state_s;

endpackage

// [scrb_top.sv]
// Function
// - Frame-synced fields: 01 at frame, 1x immediately
// - Update bits [5:4] not frame-synced; 00 blocks frame-synced updates
// - Converter clock divider code, bits 7:6, reset 00
// - Pipeline clock divider code, bits 5:4, reset 10
// - Link bit clock divider, bits 7:6, reset 01
// - Link byte clock divider, bits 4:3, reset 10
// - Pipeline and tone-map clock gates, reset on
// - Synthesizer power-down bits 5 and 3, reset 1
// - Synthesizer bypass bit 4, reset 1
// - Frame sync enable bit5, master bit4
// - Pattern input selectors bits 4:3 and 2:1
// - Sync suppress code: none, vertical, horizontal, both
// - Vertical and horizontal sync polarity invert bits
// - Horizontal sync on every line when set
// - Link enabled only when bit 6 set
// - Clock lane continuous fast mode, reset 1
// - Clock lane pin state code, reset power down
// - Data lane pin state codes, reset power down
// - Per-lane data source select, reset 10/11
// - Lane and clock pin polarity swap bits
// - Noise reduction enables per exposure
// - Pipeline digital gain enable bit 0
// - Lens shading bit 6, tone map bit 4
`timescale 1ns/1ps
module scrb_top (
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  input  wire logic [2:0] BANK,
  input  wire logic [7:0] ADDR,
  input  wire logic       WR_EN,
  input  wire logic [7:0] WR_DATA,
  input  wire logic       RD_EN,
  input  wire logic       FRAME_UPDATE,
  output logic      [7:0] RD_DATA,
  output logic      [1:0] CONV_CLK_DIV,
  output logic      [1:0] PIPE_CLK_DIV,
  output logic      [1:0] LINK_BIT_CLK_DIV,
  output logic      [1:0] LINK_BYTE_CLK_DIV,
  output logic            PIPE_CLOCK_GATE,
  output logic            TONE_MAP_CLOCK_GATE,
  output logic            SYNTH1_POWER_DOWN,
  output logic            SYNTH2_POWER_DOWN,
  output logic            SYNTH_BYPASS,
  output logic            FRAME_SYNC_ENABLE,
  output logic            FRAME_SYNC_MASTER,
  output logic      [1:0] PATTERN_INPUT_SELECT,
  output logic      [1:0] PATTERN_INPUT_SELECT_SHORTEST,
  output logic            VSYNC_SUPPRESS,
  output logic            HSYNC_SUPPRESS,
  output logic            VERTICAL_SYNC_INVERT,
  output logic            HORIZONTAL_SYNC_INVERT,
  output logic            HORIZONTAL_SYNC_EVERY_LINE,
  output logic            LINK_ENABLE,
  output logic            CLOCK_LANE_CONTINUOUS_FAST,
  output logic      [3:0] CLOCK_LANE_PIN_STATE,
  output logic      [3:0] DATA_LANE0_PIN_STATE,
  output logic      [3:0] DATA_LANE1_PIN_STATE,
  output logic      [1:0] LANE0_SOURCE_SELECT,
  output logic      [1:0] LANE1_SOURCE_SELECT,
  output logic            LANE0_PIN_POLARITY_SWAP,
  output logic            LANE1_PIN_POLARITY_SWAP,
  output logic            CLOCK_LANE_PIN_POLARITY_SWAP,
  output logic            NOISE_REDUCE_LONG_ENABLE,
  output logic            NOISE_REDUCE_SHORT_ENABLE,
  output logic            NOISE_REDUCE_SHORTEST_ENABLE,
  output logic            PIPE_DIGITAL_GAIN_ENABLE,
  output logic            LENS_SHADING_ENABLE,
  output logic            TONE_MAP_ENABLE
);

  // ***************************************************************
  // Address decode
  // ***************************************************************
  logic [scrb_pkg::NREG-1:0] hit;

  // One comparator per register
  genvar gi;
  generate
    for (gi = 0; gi < scrb_pkg::NREG; gi++) begin : g_hit
      assign hit[gi] = (BANK == scrb_pkg::REG_BANK[gi]) && (ADDR == scrb_pkg::REG_ADDR[gi]);
    end
  endgenerate

  // ***************************************************************
  // State
  // ***************************************************************
  scrb_pkg::scrb_state_s st_r;
  scrb_pkg::scrb_state_s st_nxt;
  logic [1:0]            frame_mode;

  // Mode comes from the stored copy, so a mode write acts one edge later
  assign frame_mode = st_r.shadow[scrb_pkg::IDX_UPDATE_CTRL][scrb_pkg::UPD_FRAME_LSB +: 2];

  // Shadow takes writes; active follows per update type
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < scrb_pkg::NREG; i++) begin
      if (WR_EN && hit[i]) begin
        st_nxt.shadow[i] = WR_DATA & scrb_pkg::REG_MASK[i];
      end
      if (!scrb_pkg::REG_FRAME_SYNCED[i]) begin
        st_nxt.active[i] = st_nxt.shadow[i];
      end else if (frame_mode[1]) begin
        st_nxt.active[i] = st_nxt.shadow[i];
      end else if (frame_mode == scrb_pkg::UPD_AT_FRAME && FRAME_UPDATE) begin
        // A write in the frame-point cycle waits for the next frame point
        st_nxt.active[i] = st_r.shadow[i];
      end
      // Code 00 leaves active untouched
    end
    if (RD_EN) begin
      st_nxt.rd_data = 8'h00; // Unmapped reads as zero
      for (int i = 0; i < scrb_pkg::NREG; i++) begin
        if (hit[i]) begin
          st_nxt.rd_data = st_r.shadow[i];
        end
      end
    end
  end

  // State register with constant reset
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_r.shadow  <= scrb_pkg::REG_RESET;
      st_r.active  <= scrb_pkg::REG_RESET;
      st_r.rd_data <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***************************************************************
  // Field outputs, all straight from active flops
  // ***************************************************************
  // Clocking and synthesizers
  assign CONV_CLK_DIV =
    st_r.active[scrb_pkg::IDX_CONV_PIPE_DIV][scrb_pkg::CONV_DIV_LSB +: 2];
  assign PIPE_CLK_DIV =
    st_r.active[scrb_pkg::IDX_CONV_PIPE_DIV][scrb_pkg::PIPE_DIV_LSB +: 2];
  assign LINK_BIT_CLK_DIV =
    st_r.active[scrb_pkg::IDX_LINK_CLK_DIV][scrb_pkg::BIT_DIV_LSB +: 2];
  assign LINK_BYTE_CLK_DIV =
    st_r.active[scrb_pkg::IDX_LINK_CLK_DIV][scrb_pkg::BYTE_DIV_LSB +: 2];
  assign PIPE_CLOCK_GATE =
    st_r.active[scrb_pkg::IDX_CLK_GATE][scrb_pkg::PIPE_GATE_BIT];
  assign TONE_MAP_CLOCK_GATE =
    st_r.active[scrb_pkg::IDX_CLK_GATE][scrb_pkg::TONE_GATE_BIT];
  assign SYNTH1_POWER_DOWN =
    st_r.active[scrb_pkg::IDX_SYNTH_PWR][scrb_pkg::SYNTH1_PD_BIT];
  assign SYNTH2_POWER_DOWN =
    st_r.active[scrb_pkg::IDX_SYNTH_PWR][scrb_pkg::SYNTH2_PD_BIT];
  assign SYNTH_BYPASS      = st_r.active[scrb_pkg::IDX_SYNTH_PWR][scrb_pkg::BYPASS_BIT];

  // Frame sync and test pattern
  assign FRAME_SYNC_ENABLE =
    st_r.active[scrb_pkg::IDX_FRAME_SYNC][scrb_pkg::FSYNC_EN_BIT];
  assign FRAME_SYNC_MASTER =
    st_r.active[scrb_pkg::IDX_FRAME_SYNC][scrb_pkg::FSYNC_MST_BIT];
  assign PATTERN_INPUT_SELECT =
    st_r.active[scrb_pkg::IDX_TEST_PATTERN][scrb_pkg::TP_SEL_LSB +: 2];
  assign PATTERN_INPUT_SELECT_SHORTEST =
    st_r.active[scrb_pkg::IDX_TEST_PATTERN][scrb_pkg::TP_SEL_VS_LSB +: 2];

  // Sync shaping: suppress code bit 0 vertical, bit 1 horizontal
  assign VSYNC_SUPPRESS = st_r.active[scrb_pkg::IDX_SYNC_SUPPRESS][scrb_pkg::SUPP_V_BIT];
  assign HSYNC_SUPPRESS = st_r.active[scrb_pkg::IDX_SYNC_SUPPRESS][scrb_pkg::SUPP_H_BIT];
  assign VERTICAL_SYNC_INVERT =
    st_r.active[scrb_pkg::IDX_SYNC_SHAPE][scrb_pkg::VINV_BIT];
  assign HORIZONTAL_SYNC_INVERT =
    st_r.active[scrb_pkg::IDX_SYNC_SHAPE][scrb_pkg::HINV_BIT];
  assign HORIZONTAL_SYNC_EVERY_LINE =
    st_r.active[scrb_pkg::IDX_SYNC_SHAPE][scrb_pkg::HALL_BIT];

  // Serial link pads and routing
  assign LINK_ENABLE = st_r.active[scrb_pkg::IDX_LINK_ENABLE][scrb_pkg::LINK_EN_BIT];
  assign CLOCK_LANE_CONTINUOUS_FAST =
    st_r.active[scrb_pkg::IDX_LINK_ENABLE][scrb_pkg::CK_CONT_BIT];
  assign CLOCK_LANE_PIN_STATE =
    st_r.active[scrb_pkg::IDX_CLK_PIN_STATE][scrb_pkg::CK_PIN_LSB +: 4];
  assign DATA_LANE0_PIN_STATE =
    st_r.active[scrb_pkg::IDX_DATA_PIN_STATE][scrb_pkg::D0_PIN_LSB +: 4];
  assign DATA_LANE1_PIN_STATE =
    st_r.active[scrb_pkg::IDX_DATA_PIN_STATE][scrb_pkg::D1_PIN_LSB +: 4];
  assign LANE0_SOURCE_SELECT =
    st_r.active[scrb_pkg::IDX_LANE_ROUTE][scrb_pkg::L0_SRC_LSB +: 2];
  assign LANE1_SOURCE_SELECT =
    st_r.active[scrb_pkg::IDX_LANE_ROUTE][scrb_pkg::L1_SRC_LSB +: 2];
  assign LANE0_PIN_POLARITY_SWAP =
    st_r.active[scrb_pkg::IDX_PIN_POL_SWAP][scrb_pkg::L0_SWAP_BIT];
  assign LANE1_PIN_POLARITY_SWAP =
    st_r.active[scrb_pkg::IDX_PIN_POL_SWAP][scrb_pkg::L1_SWAP_BIT];
  assign CLOCK_LANE_PIN_POLARITY_SWAP =
    st_r.active[scrb_pkg::IDX_PIN_POL_SWAP][scrb_pkg::CK_SWAP_BIT];

  // Processing stage enables
  assign NOISE_REDUCE_LONG_ENABLE =
    st_r.active[scrb_pkg::IDX_PIPE_FUNC][scrb_pkg::NR_LONG_BIT];
  assign NOISE_REDUCE_SHORT_ENABLE =
    st_r.active[scrb_pkg::IDX_PIPE_FUNC][scrb_pkg::NR_SHORT_BIT];
  assign NOISE_REDUCE_SHORTEST_ENABLE =
    st_r.active[scrb_pkg::IDX_PIPE_FUNC][scrb_pkg::NR_VSHORT_BIT];
  assign PIPE_DIGITAL_GAIN_ENABLE =
    st_r.active[scrb_pkg::IDX_PIPE_FUNC][scrb_pkg::DGAIN_BIT];
  assign LENS_SHADING_ENABLE =
    st_r.active[scrb_pkg::IDX_TONE_SHADING][scrb_pkg::LENS_BIT];
  assign TONE_MAP_ENABLE =
    st_r.active[scrb_pkg::IDX_TONE_SHADING][scrb_pkg::TONE_BIT];

  assign RD_DATA = st_r.rd_data;

endmodule

// [scrb_top_properties.sv]
`timescale 1ns/1ps
module scrb_top_check (
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic [2:0] BANK,
  input wire logic [7:0] ADDR,
  input wire logic       WR_EN,
  input wire logic [7:0] WR_DATA,
  input wire logic       RD_EN,
  input wire logic       FRAME_UPDATE,
  input wire logic [7:0] RD_DATA,
  input wire logic [1:0] CONV_CLK_DIV,
  input wire logic       HSYNC_SUPPRESS,
  input wire logic       LINK_ENABLE,
  input wire logic       LENS_SHADING_ENABLE,
  input wire logic       TONE_MAP_ENABLE,
  input wire logic [3:0] CLOCK_LANE_PIN_STATE,
  input wire logic [3:0] DATA_LANE0_PIN_STATE,
  input wire logic [3:0] DATA_LANE1_PIN_STATE,
  input wire logic [1:0] LANE0_SOURCE_SELECT,
  input wire logic [1:0] LANE1_SOURCE_SELECT,
  input wire logic       FRAME_SYNC_ENABLE,
  input wire logic       FRAME_SYNC_MASTER
);
  // ***************************************************************
  // Update mode mirror and properties
  // ***************************************************************
  logic [1:0] mode_r;
  logic [7:0] wd_r;
  logic       upd_wr_w;
  logic [5:0] fs_w;
  assign upd_wr_w = WR_EN && BANK == scrb_pkg::BANK_A && ADDR == 8'h1a;
  // Sample of frame-synced outputs; a full list would not fit
  assign fs_w = {CONV_CLK_DIV, HSYNC_SUPPRESS, LINK_ENABLE, LENS_SHADING_ENABLE, TONE_MAP_ENABLE};
  // Mode follows host writes, so no internal probe is needed
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mode_r <= 2'h1;
      wd_r   <= 8'h00;
    end else begin
      wd_r <= WR_DATA;
      if (upd_wr_w) mode_r <= WR_DATA[5:4];
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_wr(logic [2:0] b, logic [7:0] a);
    WR_EN && BANK == b && ADDR == a;
  endsequence
  sequence s_frozen;
    mode_r == 2'h0 && !upd_wr_w;
  endsequence
  sequence s_wait_frame;
    mode_r == 2'h1 && !upd_wr_w && !FRAME_UPDATE;
  endsequence
  a_ck_pin_imm : assert property (
    s_wr(scrb_pkg::BANK_F, 8'h05) |=> CLOCK_LANE_PIN_STATE == wd_r[7:4])
    else $error("clock lane pin state not applied");
  a_data_pin_imm : assert property (
    s_wr(scrb_pkg::BANK_F, 8'h06) |=> {DATA_LANE0_PIN_STATE, DATA_LANE1_PIN_STATE} == wd_r)
    else $error("data lane pin state not applied");
  a_lane_route_imm : assert property (
    s_wr(scrb_pkg::BANK_F, 8'h09) |=> {LANE0_SOURCE_SELECT, LANE1_SOURCE_SELECT} == wd_r[3:0])
    else $error("lane source select not applied");
  a_fsync_role_imm : assert property (
    s_wr(scrb_pkg::BANK_B, 8'h0a) |=> {FRAME_SYNC_ENABLE, FRAME_SYNC_MASTER} == wd_r[5:4])
    else $error("frame sync role not applied");
  a_frozen_hold : assert property (
    s_frozen |=> $stable(fs_w))
    else $error("output moved while updates blocked");
  a_frame_wait_hold : assert property (
    s_wait_frame |=> $stable(fs_w))
    else $error("output moved before frame point");
  a_imm_apply : assert property (
    mode_r[1] && WR_EN && BANK == scrb_pkg::BANK_H && ADDR == 8'h04
    |=> LENS_SHADING_ENABLE == wd_r[6] && TONE_MAP_ENABLE == wd_r[4])
    else $error("immediate update not applied");
  a_rd_unimpl_zero : assert property (
    RD_EN && BANK == scrb_pkg::BANK_A && ADDR == 8'h4e
    |=> RD_DATA[7:6] == 2'h0 ##0 RD_DATA[2:0] == 3'h0)
    else $error("unimplemented bits read nonzero");
  a_rd_data_hold : assert property (
    !RD_EN |=> $stable(RD_DATA))
    else $error("read data moved without read");
endmodule

// [scrb_host.sv]
`timescale 1ns/1ps
module scrb_host (
  input  wire logic       REF_CLK,
  input  wire logic [7:0] RD_DATA,
  output logic      [2:0] BANK,
  output logic      [7:0] ADDR,
  output logic            WR_EN,
  output logic      [7:0] WR_DATA,
  output logic            RD_EN
);
  // ***************************************************************
  // Host register access
  // ***************************************************************
  initial begin
    BANK = 3'h0;
    ADDR = 8'h00;
    WR_EN = 1'b0;
    WR_DATA = 8'h00;
    RD_EN = 1'b0;
  end
  // Released address and data lines show the inverse so no stale value is reused
  task automatic wr(input logic [2:0] b, input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    BANK <= b;
    ADDR <= a;
    WR_DATA <= d;
    WR_EN <= 1'b1;
    @(posedge REF_CLK);
    WR_EN <= 1'b0;
    ADDR <= ~a;
    WR_DATA <= ~d;
    #1;
  endtask
  // Data is registered at the taking edge and sampled 1 ns after it
  task automatic rd(input logic [2:0] b, input logic [7:0] a, output logic [7:0] d);
    @(posedge REF_CLK);
    BANK <= b;
    ADDR <= a;
    RD_EN <= 1'b1;
    @(posedge REF_CLK);
    RD_EN <= 1'b0;
    ADDR <= ~a;
    #1;
    d = RD_DATA;
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic       REF_CLK, RST, FRAME_UPDATE, WR_EN, RD_EN;
  logic [2:0] BANK;
  logic [7:0] ADDR, WR_DATA, RD_DATA, rd_v;
  logic [1:0] CONV_CLK_DIV, PIPE_CLK_DIV, LINK_BIT_CLK_DIV, LINK_BYTE_CLK_DIV;
  logic [1:0] PATTERN_INPUT_SELECT, PATTERN_INPUT_SELECT_SHORTEST;
  logic [1:0] LANE0_SOURCE_SELECT, LANE1_SOURCE_SELECT;
  logic [3:0] CLOCK_LANE_PIN_STATE, DATA_LANE0_PIN_STATE, DATA_LANE1_PIN_STATE;
  logic       PIPE_CLOCK_GATE, TONE_MAP_CLOCK_GATE, SYNTH1_POWER_DOWN, SYNTH2_POWER_DOWN;
  logic       SYNTH_BYPASS, FRAME_SYNC_ENABLE, FRAME_SYNC_MASTER, VSYNC_SUPPRESS;
  logic       HSYNC_SUPPRESS, VERTICAL_SYNC_INVERT, HORIZONTAL_SYNC_INVERT;
  logic       HORIZONTAL_SYNC_EVERY_LINE, LINK_ENABLE, CLOCK_LANE_CONTINUOUS_FAST;
  logic       LANE0_PIN_POLARITY_SWAP, LANE1_PIN_POLARITY_SWAP, CLOCK_LANE_PIN_POLARITY_SWAP;
  logic       NOISE_REDUCE_LONG_ENABLE, NOISE_REDUCE_SHORT_ENABLE, NOISE_REDUCE_SHORTEST_ENABLE;
  logic       PIPE_DIGITAL_GAIN_ENABLE, LENS_SHADING_ENABLE, TONE_MAP_ENABLE;
  int         error_cnt = 0;
  int         n_compared = 0;
  scrb_top  uut (.*);
  scrb_host host (.*);
  // ***************************************************************
  // Clock, checks and scenarios
  // ***************************************************************
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One frame point pulse, outputs sampled after it lands
  task automatic frame;
    @(posedge REF_CLK);
    FRAME_UPDATE <= 1'b1;
    @(posedge REF_CLK);
    FRAME_UPDATE <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    chk({CONV_CLK_DIV, PIPE_CLK_DIV}, 8'h02);
    chk({LINK_BIT_CLK_DIV, LINK_BYTE_CLK_DIV}, 8'h06);
    chk({PIPE_CLOCK_GATE, TONE_MAP_CLOCK_GATE}, 8'h03);
    chk({SYNTH1_POWER_DOWN, SYNTH2_POWER_DOWN, SYNTH_BYPASS}, 8'h07);
    chk({LINK_ENABLE, CLOCK_LANE_CONTINUOUS_FAST}, 8'h01);
    chk({CLOCK_LANE_PIN_STATE, DATA_LANE0_PIN_STATE}, 8'haa);
    chk({LANE0_SOURCE_SELECT, LANE1_SOURCE_SELECT, DATA_LANE1_PIN_STATE}, 8'hba);
    for (int i = 0; i < scrb_pkg::NREG; i++) begin
      host.rd(scrb_pkg::REG_BANK[i], scrb_pkg::REG_ADDR[i], rd_v);
      chk(rd_v, scrb_pkg::REG_RESET[i]);
    end
  endtask
  // Mode 01: outputs wait for the frame point, reads do not
  task automatic t_frame;
    host.wr(scrb_pkg::BANK_A, 8'h56, 8'hd0);
    chk(CONV_CLK_DIV, 8'h00);
    host.rd(scrb_pkg::BANK_A, 8'h56, rd_v);
    chk(rd_v, 8'hd0);
    host.wr(scrb_pkg::BANK_A, 8'h57, 8'h98);
    host.wr(scrb_pkg::BANK_A, 8'h58, 8'h40);
    host.wr(scrb_pkg::BANK_G, 8'h06, 8'he1);
    frame();
    chk({CONV_CLK_DIV, PIPE_CLK_DIV}, 8'h0d);
    chk({LINK_BIT_CLK_DIV, LINK_BYTE_CLK_DIV}, 8'h0b);
    chk({PIPE_CLOCK_GATE, TONE_MAP_CLOCK_GATE}, 8'h01);
    chk({NOISE_REDUCE_LONG_ENABLE, NOISE_REDUCE_SHORT_ENABLE,
         NOISE_REDUCE_SHORTEST_ENABLE, PIPE_DIGITAL_GAIN_ENABLE}, 8'h0f);
  endtask
  // Mode 00 freezes, then mode 1x releases pending values
  task automatic t_block;
    host.wr(scrb_pkg::BANK_A, 8'h1a, 8'h40);
    host.wr(scrb_pkg::BANK_A, 8'had, 8'h60);
    host.wr(scrb_pkg::BANK_A, 8'hae, 8'h70);
    host.wr(scrb_pkg::BANK_F, 8'h04, 8'h40);
    frame();
    chk({VSYNC_SUPPRESS, HSYNC_SUPPRESS, LINK_ENABLE, CLOCK_LANE_CONTINUOUS_FAST}, 8'h01);
    host.wr(scrb_pkg::BANK_A, 8'h1a, 8'h60);
    // New mode acts from the stored copy, one edge after its write
    @(posedge REF_CLK);
    #1;
    chk({VSYNC_SUPPRESS, HSYNC_SUPPRESS, LINK_ENABLE,
         CLOCK_LANE_CONTINUOUS_FAST}, 8'h0e);
    chk({VERTICAL_SYNC_INVERT, HORIZONTAL_SYNC_EVERY_LINE,
         HORIZONTAL_SYNC_INVERT}, 8'h07);
    host.wr(scrb_pkg::BANK_A, 8'had, 8'h20);
    chk({VSYNC_SUPPRESS, HSYNC_SUPPRESS}, 8'h02);
    host.wr(scrb_pkg::BANK_A, 8'had, 8'h40);
    chk({VSYNC_SUPPRESS, HSYNC_SUPPRESS}, 8'h01);
    host.wr(scrb_pkg::BANK_H, 8'h04, 8'h50);
    chk({LENS_SHADING_ENABLE, TONE_MAP_ENABLE}, 8'h03);
  endtask
  task automatic t_imm;
    logic [7:0] v;
    for (int c = 0; c < 11; c++) begin
      v = {c[3:0], 4'ha - c[3:0]};
      host.wr(scrb_pkg::BANK_F, 8'h05, v);
      chk(CLOCK_LANE_PIN_STATE, v[7:4]);
      host.wr(scrb_pkg::BANK_F, 8'h06, v);
      chk({DATA_LANE0_PIN_STATE, DATA_LANE1_PIN_STATE}, v);
    end
    host.wr(scrb_pkg::BANK_F, 8'h09, 8'h04);
    chk({LANE0_SOURCE_SELECT, LANE1_SOURCE_SELECT}, 8'h04);
    host.wr(scrb_pkg::BANK_F, 8'h0b, 8'hc8);
    chk({LANE0_PIN_POLARITY_SWAP, LANE1_PIN_POLARITY_SWAP,
         CLOCK_LANE_PIN_POLARITY_SWAP}, 8'h07);
    host.wr(scrb_pkg::BANK_B, 8'h0a, 8'h30);
    chk({FRAME_SYNC_ENABLE, FRAME_SYNC_MASTER}, 8'h03);
    host.wr(scrb_pkg::BANK_B, 8'h11, 8'h16);
    chk({PATTERN_INPUT_SELECT, PATTERN_INPUT_SELECT_SHORTEST}, 8'h0b);
    host.wr(scrb_pkg::BANK_A, 8'h4e, 8'hff);
    host.rd(scrb_pkg::BANK_A, 8'h4e, rd_v);
    chk(rd_v, 8'h38);
    host.wr(scrb_pkg::BANK_A, 8'h4e, 8'h00);
    chk({SYNTH1_POWER_DOWN, SYNTH2_POWER_DOWN, SYNTH_BYPASS}, 8'h00);
  endtask
  // Unmapped place: write lost, neighbours untouched
  task automatic t_unmapped;
    host.wr(scrb_pkg::BANK_A, 8'h00, 8'hff);
    host.rd(scrb_pkg::BANK_A, 8'h00, rd_v);
    chk(rd_v, 8'h00);
    host.rd(scrb_pkg::BANK_A, 8'h56, rd_v);
    chk(rd_v, 8'hd0);
  endtask
  // Reset again mid-run: async clear, then every reset value back
  task automatic t_reset_again;
    @(posedge REF_CLK);
    RST <= 1'b1;
    #1;
    chk({LANE0_SOURCE_SELECT, LANE1_SOURCE_SELECT}, 8'h0b);
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    #1;
    t_reset();
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    RST = 1'b1;
    FRAME_UPDATE = 1'b0;
    repeat (10) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    #1;
    t_reset();
    t_frame();
    t_block();
    t_imm();
    t_unmapped();
    t_reset_again();
    print_verdict();
  end
endmodule
bind scrb_top scrb_top_check u_chk (.*);
